// [fpdc_defines.svh]
// register offsets, control fields, reset values and timing of the pll divider control
`ifndef FPDC_DEFINES_SVH
`define FPDC_DEFINES_SVH
`define FPDC_ADDR_FIRST_FB 8'h00
`define FPDC_ADDR_SECOND_FB 8'h04
`define FPDC_ADDR_R 8'h08
`define FPDC_ADDR_CTRL 8'h0C
`define FPDC_ADDR_STATUS 8'h10
`define FPDC_ADDR_ACTIVE 8'h14
`define FPDC_B_NSEL 0
`define FPDC_B_SHIFT_N 1
`define FPDC_B_FRAC_N 2
`define FPDC_B_HCSEL 3
`define FPDC_F_DELAY1 5:4
`define FPDC_F_DELAY2 7:6
`define FPDC_B_HCCUR 8
`define FPDC_B_LCCUR 9
`define FPDC_B_LFSEL 10
`define FPDC_B_WIRE 11
`define FPDC_B_CORR 12
`define FPDC_F_PRESC 16:13
`define FPDC_CTRL_W 17
`define FPDC_N_RST 18'h00000
`define FPDC_R_RST 14'h0000
`define FPDC_CTRL_RST 17'h00006
`define FPDC_PRESC_MAX 4'hA
`define FPDC_CLK_MHZ 50
`define FPDC_DELAY1_US 100
`define FPDC_DELAY2_US 200
`define FPDC_DELAY3_US 400
`endif

// [fpdc_pkg.sv]
// types shared by the pll divider control modules
`default_nettype none
package fpdc_pkg;
  typedef enum logic {HC_LOCKED, HC_FAST} fpdc_hc_state_t;
endpackage
`default_nettype wire

// [fpdc_pfd_if.sv]
// carrier between the divider control and the phase comparator
`timescale 1ns/1ps
`default_nettype none
interface fpdc_pfd_if;
  logic ref_pulse;
  logic fb_pulse;
  logic up;
  logic dn;
  modport cmp (input ref_pulse, input fb_pulse, output up, output dn);
  modport ctl (output ref_pulse, output fb_pulse, input up, input dn);
endinterface
`default_nettype wire

// [fpdc_divider.sv]
// programmable tick divider with one extra count on request
`timescale 1ns/1ps
`default_nettype none
module fpdc_divider
#(
  parameter int unsigned W = 18
)(
  input wire logic clock,
  input wire logic srst,
  input wire logic tick,
  input wire logic [W-1:0] divisor,
  input wire logic extra,
  output logic out_pulse
);
  if (W < 2)
  begin : g_bad_w
    $error("divider width too small");
  end

  logic [W:0] cnt_r;
  wire [W:0] term = {1'b0, divisor} - {{W{1'b0}}, 1'b1} + {{W{1'b0}}, extra};
  // a zero divisor stops the output instead of wrapping
  wire hit = tick && (divisor != '0) && (cnt_r >= term);

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cnt_r <= '0;
      out_pulse <= 1'b0;
    end
    else
    begin
      out_pulse <= hit;
      if (hit)
        cnt_r <= '0;
      else if (tick)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  property p_div_wrap;
    @(posedge clock) disable iff (srst)
    hit |=> (cnt_r == '0) && out_pulse;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("divider did not wrap on terminal count");
endmodule
`default_nettype wire

// [fpdc_pfd.sv]
// phase comparator driving the source and sink of the charge pumps
`timescale 1ns/1ps
`default_nettype none
module fpdc_pfd
(
  input wire logic clock,
  input wire logic srst,
  fpdc_pfd_if.cmp bus
);
  logic up_r;
  logic dn_r;
  wire up_nxt = up_r | bus.ref_pulse;
  wire dn_nxt = dn_r | bus.fb_pulse;
  // once both edges have arrived the pumps reset together
  wire both = up_nxt & dn_nxt;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else
    begin
      up_r <= up_nxt & ~both;
      dn_r <= dn_nxt & ~both;
    end
  end

  assign bus.up = up_r;
  assign bus.dn = dn_r;

  property p_pfd_lead;
    @(posedge clock) disable iff (srst)
    bus.ref_pulse && !bus.fb_pulse && !dn_r |=> up_r && !dn_r;
  endproperty
  a_pfd_lead: assert property (p_pfd_lead) else $error("reference lead did not raise source");
endmodule
`default_nettype wire

// [fpdc_top.sv]
// digital control of the fractional pll synthesizer dividers and charge pumps
//
// How it works
// - two 18-bit feedback latches, one 14-bit reference latch
// - one bit selects active feedback latch
// - shift mode divides both divisors by four
// - low two reference bits unused in shift mode
// - fractional mode in shift mode feeds low feedback bits to accumulator
// - dual modulus N or N+1 only when fractional
// - four fractional steps: whole, quarter, half, three quarters
// - fractional off in shift mode drops low bits
// - phase comparator drives pump source and sink
// - one bit selects active fast-pump delay setting
// - each delay setting has its own two-bit field
// - high pump during change, bit picks 1/2 mA
// - low pump when locked, bit picks 50/100 uA
// - zero delay field keeps high pump off
// - one bit routes pump to AM or FM filter
// - spur compensation needs wire switch and correction pump
// - correction pump has its own enable bit
// - AM prescaler: no division or 2 to 10
`timescale 1ns/1ps
`default_nettype none
`include "fpdc_defines.svh"
module fpdc_top
  import fpdc_pkg::*;
#(
  parameter int unsigned N_W = 18,
  parameter int unsigned R_W = 14,
  parameter int unsigned HC_CYC_1 = `FPDC_DELAY1_US * `FPDC_CLK_MHZ,
  parameter int unsigned HC_CYC_2 = `FPDC_DELAY2_US * `FPDC_CLK_MHZ,
  parameter int unsigned HC_CYC_3 = `FPDC_DELAY3_US * `FPDC_CLK_MHZ
)(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ref_clk_in,
  input wire logic vco_fb_in,
  output logic pump_source,
  output logic pump_sink,
  output logic hc_pump_en,
  output logic hc_pump_2ma,
  output logic lc_pump_en,
  output logic lc_pump_100ua,
  output logic am_loop_filter_out,
  output logic fm_loop_filter_out,
  output logic spur_comp_en,
  output logic corr_pump_en,
  output logic am_lo_out
);
  if (N_W != 18 || R_W != 14)
  begin : g_bad_width
    $error("latch widths must stay 18 and 14 bits");
  end
  if (HC_CYC_1 < 1 || HC_CYC_2 < 1 || HC_CYC_3 < 1 || HC_CYC_3 > 65536)
  begin : g_bad_delay
    $error("fast-pump delay counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  logic [N_W-1:0] first_feedback_divisor_r;
  logic [N_W-1:0] second_feedback_divisor_r;
  logic [R_W-1:0] r_r;
  logic [`FPDC_CTRL_W-1:0] ctrl_r;
  logic [31:0] rdata_r;

  wire sel_first = (reg_addr == `FPDC_ADDR_FIRST_FB);
  wire sel_second = (reg_addr == `FPDC_ADDR_SECOND_FB);
  wire sel_r = (reg_addr == `FPDC_ADDR_R);
  wire sel_ctrl = (reg_addr == `FPDC_ADDR_CTRL);
  wire sel_status = (reg_addr == `FPDC_ADDR_STATUS);
  wire sel_active = (reg_addr == `FPDC_ADDR_ACTIVE);

  // the serial front end presents each finished frame as one write
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      first_feedback_divisor_r <= `FPDC_N_RST;
      second_feedback_divisor_r <= `FPDC_N_RST;
      r_r <= `FPDC_R_RST;
      ctrl_r <= `FPDC_CTRL_RST;
    end
    else if (reg_wr)
    begin
      if (sel_first)
        first_feedback_divisor_r <= reg_wdata[N_W-1:0];
      else if (sel_second)
        second_feedback_divisor_r <= reg_wdata[N_W-1:0];
      else if (sel_r)
        r_r <= reg_wdata[R_W-1:0];
      else if (sel_ctrl)
        ctrl_r <= reg_wdata[`FPDC_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor selection, shift and fractional part

  wire shift_on = ~ctrl_r[`FPDC_B_SHIFT_N];
  wire frac_on = ~ctrl_r[`FPDC_B_FRAC_N];
  wire dual_mod = shift_on & frac_on;
  wire [N_W-1:0] active_n = ctrl_r[`FPDC_B_NSEL] ? second_feedback_divisor_r
                                                 : first_feedback_divisor_r;
  wire [N_W-1:0] n_div = shift_on ? {2'b00, active_n[N_W-1:2]} : active_n;
  // the host keeps the two low reference bits zero, so they are simply dropped
  wire [R_W-1:0] r_div = shift_on ? {2'b00, r_r[R_W-1:2]} : r_r;
  wire [1:0] frac = dual_mod ? active_n[1:0] : 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finders

  logic ref_meta_r;
  logic ref_sync_r;
  logic ref_prev_r;
  logic fb_meta_r;
  logic fb_sync_r;
  logic fb_prev_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ref_meta_r <= 1'b0;
      ref_sync_r <= 1'b0;
      ref_prev_r <= 1'b0;
      fb_meta_r <= 1'b0;
      fb_sync_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end
    else
    begin
      ref_meta_r <= ref_clk_in;
      ref_sync_r <= ref_meta_r;
      ref_prev_r <= ref_sync_r;
      fb_meta_r <= vco_fb_in;
      fb_sync_r <= fb_meta_r;
      fb_prev_r <= fb_sync_r;
    end
  end

  wire ref_rise = ref_sync_r & ~ref_prev_r;
  wire fb_rise = fb_sync_r & ~fb_prev_r;
  wire fb_edge = fb_sync_r ^ fb_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // fraction accumulator and dual-modulus switch

  logic [1:0] acc_r;
  logic plus1_r;
  logic fb_pulse;
  logic ref_pulse;
  wire [2:0] acc_sum = {1'b0, acc_r} + {1'b0, frac};

  // a carry out of the accumulator stretches the next feedback cycle by one
  always_ff @(posedge clock)
  begin
    if (srst || !dual_mod)
    begin
      acc_r <= 2'b00;
      plus1_r <= 1'b0;
    end
    else if (fb_pulse)
    begin
      acc_r <= acc_sum[1:0];
      plus1_r <= acc_sum[2];
    end
  end

  fpdc_divider #(.W(N_W)) u_fb_div (
    .clock(clock),
    .srst(srst),
    .tick(fb_rise),
    .divisor(n_div),
    .extra(plus1_r),
    .out_pulse(fb_pulse)
  );

  fpdc_divider #(.W(R_W)) u_ref_div (
    .clock(clock),
    .srst(srst),
    .tick(ref_rise),
    .divisor(r_div),
    .extra(1'b0),
    .out_pulse(ref_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // phase comparator

  fpdc_pfd_if pfd_bus ();

  assign pfd_bus.ref_pulse = ref_pulse;
  assign pfd_bus.fb_pulse = fb_pulse;

  fpdc_pfd u_pfd (
    .clock(clock),
    .srst(srst),
    .bus(pfd_bus.cmp)
  );

  assign pump_source = pfd_bus.up;
  assign pump_sink = pfd_bus.dn;

  ////////////////////////////////////////////////////////////////////////////
  // fast-pump window

  wire [1:0] hc_code = ctrl_r[`FPDC_B_HCSEL] ? ctrl_r[`FPDC_F_DELAY2]
                                             : ctrl_r[`FPDC_F_DELAY1];
  wire [15:0] hc_len = (hc_code == 2'b01) ? 16'(HC_CYC_1 - 1)
                     : (hc_code == 2'b10) ? 16'(HC_CYC_2 - 1)
                     : 16'(HC_CYC_3 - 1);

  logic [N_W-1:0] act_n_r;
  wire div_change = (active_n != act_n_r);

  fpdc_hc_state_t state_r;
  fpdc_hc_state_t state_nxt;
  logic [15:0] hc_cnt_r;
  logic [15:0] hc_cnt_nxt;

  always_comb
  begin
    state_nxt = state_r;
    hc_cnt_nxt = hc_cnt_r;
    case (state_r)
      HC_LOCKED:
        if (div_change && hc_code != 2'b00)
        begin
          state_nxt = HC_FAST;
          hc_cnt_nxt = hc_len;
        end
      HC_FAST:
        if (hc_code == 2'b00)
          state_nxt = HC_LOCKED;
        else if (div_change)
          hc_cnt_nxt = hc_len;
        else if (hc_cnt_r == 16'h0000)
          state_nxt = HC_LOCKED;
        else
          hc_cnt_nxt = hc_cnt_r - 16'h0001;
      default:
        state_nxt = HC_LOCKED;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= HC_LOCKED;
      hc_cnt_r <= 16'h0000;
      act_n_r <= `FPDC_N_RST;
    end
    else
    begin
      state_r <= state_nxt;
      hc_cnt_r <= hc_cnt_nxt;
      act_n_r <= active_n;
    end
  end

  // a zeroed delay field cuts the high pump at once, even mid-window
  assign hc_pump_en = (state_r == HC_FAST) && (hc_code != 2'b00);
  assign lc_pump_en = ~hc_pump_en;
  assign hc_pump_2ma = ctrl_r[`FPDC_B_HCCUR];
  assign lc_pump_100ua = ctrl_r[`FPDC_B_LCCUR];

  ////////////////////////////////////////////////////////////////////////////
  // loop filter routing and spur compensation

  assign am_loop_filter_out = ~ctrl_r[`FPDC_B_LFSEL];
  assign fm_loop_filter_out = ctrl_r[`FPDC_B_LFSEL];
  assign corr_pump_en = ctrl_r[`FPDC_B_CORR];
  assign spur_comp_en = dual_mod & ctrl_r[`FPDC_B_WIRE] & ctrl_r[`FPDC_B_CORR];

  ////////////////////////////////////////////////////////////////////////////
  // AM prescaler

  wire [3:0] presc_code = ctrl_r[`FPDC_F_PRESC];
  // codes 0 and 1 pass the oscillator through, codes above ten clamp to ten
  wire [3:0] presc_div = (presc_code <= 4'h1) ? 4'h1
                       : (presc_code > `FPDC_PRESC_MAX) ? `FPDC_PRESC_MAX
                       : presc_code;
  logic lo_pulse;
  logic am_lo_r;

  // both oscillator edges count, so a toggle every d edges divides by d
  fpdc_divider #(.W(4)) u_presc (
    .clock(clock),
    .srst(srst),
    .tick(fb_edge),
    .divisor(presc_div),
    .extra(1'b0),
    .out_pulse(lo_pulse)
  );

  always_ff @(posedge clock)
  begin
    if (srst)
      am_lo_r <= 1'b0;
    else if (lo_pulse)
      am_lo_r <= ~am_lo_r;
  end

  assign am_lo_out = am_lo_r;

  ////////////////////////////////////////////////////////////////////////////
  // read back

  wire [31:0] status_word = {29'h0, plus1_r, hc_pump_en, state_r == HC_LOCKED};
  wire [31:0] rd_mux = sel_first ? {14'h0, first_feedback_divisor_r}
                     : sel_second ? {14'h0, second_feedback_divisor_r}
                     : sel_r ? {18'h0, r_r}
                     : sel_ctrl ? {15'h0, ctrl_r}
                     : sel_status ? status_word
                     : sel_active ? {14'h0, n_div}
                     : 32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (srst)
      rdata_r <= 32'h0000_0000;
    else if (reg_rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 32'h0000_0000;
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_nsel;
    @(posedge clock) disable iff (srst)
    reg_wr && sel_ctrl && reg_wdata[`FPDC_B_NSEL] && reg_wdata[`FPDC_B_SHIFT_N]
      |=> n_div == second_feedback_divisor_r;
  endproperty
  a_nsel: assert property (p_nsel) else $error("second latch not routed");

  property p_shift;
    @(posedge clock) disable iff (srst)
    reg_wr && sel_ctrl && !reg_wdata[`FPDC_B_SHIFT_N] |=> r_div == {2'b00, r_r[R_W-1:2]};
  endproperty
  a_shift: assert property (p_shift) else $error("reference not shifted");

  property p_nomod;
    @(posedge clock) disable iff (srst)
    !dual_mod |=> !plus1_r && acc_r == 2'b00;
  endproperty
  a_nomod: assert property (p_nomod) else $error("modulus switched outside fractional shift");

  property p_frac;
    @(posedge clock) disable iff (srst)
    dual_mod && fb_pulse ##1 dual_mod |-> acc_r == $past(acc_sum[1:0]) && plus1_r == $past(acc_sum[2]);
  endproperty
  a_frac: assert property (p_frac) else $error("fraction accumulator wrong");

  property p_hczero;
    @(posedge clock) disable iff (srst)
    hc_code == 2'b00 |-> !hc_pump_en && lc_pump_en;
  endproperty
  a_hczero: assert property (p_hczero) else $error("high pump on with zero delay");

  property p_hcstart;
    @(posedge clock) disable iff (srst)
    div_change && hc_code == 2'b01 ##1 hc_code == 2'b01 |-> hc_pump_en && hc_cnt_r == 16'(HC_CYC_1 - 1);
  endproperty
  a_hcstart: assert property (p_hcstart) else $error("high-current window not opened");

  property p_lfsel;
    @(posedge clock) disable iff (srst)
    reg_wr && sel_ctrl |=> fm_loop_filter_out == $past(reg_wdata[`FPDC_B_LFSEL]) && am_loop_filter_out != fm_loop_filter_out;
  endproperty
  a_lfsel: assert property (p_lfsel) else $error("loop filter routing wrong");

  property p_spur;
    @(posedge clock) disable iff (srst)
    spur_comp_en |-> ctrl_r[`FPDC_B_WIRE] && corr_pump_en && shift_on && frac_on;
  endproperty
  a_spur: assert property (p_spur) else $error("spur compensation without its enables");
endmodule
`default_nettype wire

// [fpdc_osc_model.sv]
// reference oscillator and vco sources feeding the divider pins
`timescale 1ns/1ps
`default_nettype none
module fpdc_osc_model
(
  input wire logic [15:0] ref_half,
  input wire logic [15:0] vco_half,
  output logic ref_clk,
  output logic vco_clk
);
  initial ref_clk = 1'b0;
  initial vco_clk = 1'b0;
  // a half period of zero parks the source low
  always
  begin
    #(ref_half == 16'h0000 ? 16'h000A : ref_half);
    ref_clk = (ref_half == 16'h0000) ? 1'b0 : ~ref_clk;
  end
  always
  begin
    #(vco_half == 16'h0000 ? 16'h000A : vco_half);
    vco_clk = (vco_half == 16'h0000) ? 1'b0 : ~vco_clk;
  end
endmodule
`default_nettype wire

// [fpdc_top_tb.sv]
// self-checking bench of the pll divider control
`timescale 1ns/1ps
`default_nettype none
`include "fpdc_defines.svh"
module fpdc_top_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ref_clk_in, vco_fb_in, pump_source, pump_sink, hc_pump_en, hc_pump_2ma;
  logic lc_pump_en, lc_pump_100ua, am_loop_filter_out, fm_loop_filter_out;
  logic spur_comp_en, corr_pump_en, am_lo_out;
  logic [15:0] ref_half = 16'h0050;
  logic [15:0] vco_half = 16'h0050;
  int error_cnt = 0;
  int n_checks = 0;
  fpdc_top #(.HC_CYC_1(8), .HC_CYC_2(16), .HC_CYC_3(32)) uut (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in), .vco_fb_in(vco_fb_in),
    .pump_source(pump_source), .pump_sink(pump_sink), .hc_pump_en(hc_pump_en),
    .hc_pump_2ma(hc_pump_2ma), .lc_pump_en(lc_pump_en), .lc_pump_100ua(lc_pump_100ua),
    .am_loop_filter_out(am_loop_filter_out), .fm_loop_filter_out(fm_loop_filter_out),
    .spur_comp_en(spur_comp_en), .corr_pump_en(corr_pump_en), .am_lo_out(am_lo_out));
  fpdc_osc_model osc (.ref_half(ref_half), .vco_half(vco_half), .ref_clk(ref_clk_in),
    .vco_clk(vco_fb_in));
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(what, exp, q);
  endtask
  // counts cycles with the high-current pump on, checking the low pump is its inverse
  task automatic hc_window(input logic [31:0] fb_val, input int exp);
    int n;
    n = 0;
    wr(`FPDC_ADDR_FIRST_FB, fb_val);
    repeat (48)
    begin
      @(posedge clock);
      #1;
      n += (hc_pump_en === 1'b1);
      chk("lc_pump_en", {31'h0, ~hc_pump_en}, {31'h0, lc_pump_en});
    end
    chk("hc_cycles", exp, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk("ctrl", `FPDC_ADDR_CTRL, 32'h00000006);
    rdchk("first_fb", `FPDC_ADDR_FIRST_FB, 32'h00000000);
    rdchk("unmapped", 8'hFC, 32'h00000000);
    chk("lc_en", 32'h1, {31'h0, lc_pump_en});
    chk("am_lf", 32'h1, {31'h0, am_loop_filter_out});
  endtask
  task automatic t_latch();
    wr(`FPDC_ADDR_FIRST_FB, 32'hFFFFFFFF);
    wr(`FPDC_ADDR_SECOND_FB, 32'hFFFFFFFF);
    wr(`FPDC_ADDR_R, 32'hFFFFFFFF);
    rdchk("first_fb", `FPDC_ADDR_FIRST_FB, 32'h0003FFFF);
    rdchk("second_fb", `FPDC_ADDR_SECOND_FB, 32'h0003FFFF);
    rdchk("r", `FPDC_ADDR_R, 32'h00003FFF);
  endtask
  task automatic t_mux();
    wr(`FPDC_ADDR_FIRST_FB, 32'h00000008);
    wr(`FPDC_ADDR_SECOND_FB, 32'h0000000D);
    wr(`FPDC_ADDR_R, 32'h00000010);
    rdchk("active", `FPDC_ADDR_ACTIVE, 32'h00000008);
    wr(`FPDC_ADDR_CTRL, 32'h00000007);
    rdchk("active", `FPDC_ADDR_ACTIVE, 32'h0000000D);
    wr(`FPDC_ADDR_CTRL, 32'h00000005);
    rdchk("active", `FPDC_ADDR_ACTIVE, 32'h00000003);
  endtask
  // the n+1 flag shows up only with shift and fraction on and a nonzero fraction
  task automatic t_frac();
    logic [31:0] q;
    logic seen;
    for (int m = 0; m < 8; m++)
    begin
      wr(`FPDC_ADDR_CTRL, (m >= 4) ? 32'h00000004 : 32'h00000000);
      wr(`FPDC_ADDR_FIRST_FB, 32'h00000008 | (m % 4));
      seen = 1'b0;
      repeat (150)
      begin
        rd(`FPDC_ADDR_STATUS, q);
        seen |= q[2];
      end
      chk("n_plus_1", {31'h0, m > 0 && m < 4}, {31'h0, seen});
    end
  endtask
  task automatic t_pumps();
    wr(`FPDC_ADDR_CTRL, 32'h00001706);
    #1;
    chk("hc_2ma", 32'h1, {31'h0, hc_pump_2ma});
    chk("lc_100ua", 32'h1, {31'h0, lc_pump_100ua});
    chk("route", 32'h2, {30'h0, fm_loop_filter_out, am_loop_filter_out});
    chk("corr", 32'h1, {31'h0, corr_pump_en});
    chk("spur", 32'h0, {31'h0, spur_comp_en});
    wr(`FPDC_ADDR_CTRL, 32'h00001800);
    #1;
    chk("currents", 32'h0, {30'h0, hc_pump_2ma, lc_pump_100ua});
    chk("spur", 32'h1, {31'h0, spur_comp_en});
    wr(`FPDC_ADDR_CTRL, 32'h00001804);
    #1;
    chk("spur", 32'h0, {31'h0, spur_comp_en});
    wr(`FPDC_ADDR_CTRL, 32'h00000800);
    #1;
    chk("corr_spur", 32'h0, {30'h0, corr_pump_en, spur_comp_en});
  endtask
  task automatic t_hc();
    wr(`FPDC_ADDR_CTRL, 32'h00000016);
    hc_window(32'h00000020, 8);
    wr(`FPDC_ADDR_CTRL, 32'h0000008E);
    hc_window(32'h00000024, 16);
    wr(`FPDC_ADDR_CTRL, 32'h0000001E);
    hc_window(32'h00000028, 0);
  endtask
  // with the reference faster the source dominates, with the vco faster the sink
  task automatic t_pfd();
    int src;
    int snk;
    wr(`FPDC_ADDR_CTRL, 32'h00000006);
    wr(`FPDC_ADDR_FIRST_FB, 32'h00000004);
    wr(`FPDC_ADDR_R, 32'h00000004);
    for (int k = 0; k < 2; k++)
    begin
      ref_half <= (k == 0) ? 16'h0028 : 16'h00A0;
      src = 0;
      snk = 0;
      repeat (2000)
      begin
        @(posedge clock);
        #1;
        src += (pump_source === 1'b1);
        snk += (pump_sink === 1'b1);
      end
      chk("src_gt_snk", {31'h0, k == 0}, {31'h0, src > snk});
    end
  endtask
  task automatic t_presc();
    int codes[4] = '{0, 2, 5, 10};
    int tg;
    int dv;
    logic last;
    foreach (codes[i])
    begin
      wr(`FPDC_ADDR_CTRL, 32'h00000006 | (codes[i] << 13));
      dv = (codes[i] < 2) ? 1 : codes[i];
      tg = 0;
      last = am_lo_out;
      repeat (800)
      begin
        @(posedge clock);
        #1;
        tg += (am_lo_out !== last);
        last = am_lo_out;
      end
      chk("presc_toggles", 32'h1, {31'h0, (tg - 200 / dv) <= 2 && (200 / dv - tg) <= 2});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_latch();
    t_mux();
    t_frac();
    t_pumps();
    t_hc();
    t_pfd();
    t_presc();
    conclude();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
